/* dv/acd_clock_config_properties.sv */
`timescale 1ns/1ps
module acd_clock_config_properties (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sync_master_mode_i,
  input wire logic        serial_clock_o,
  input wire logic        serial_clock_oe_o,
  input wire logic        internal_divided_clock_o,
  input wire logic        modulator_clock_o,
  input wire logic        sample_strobe_o
);
  // ******************************
  // bus and clock output checks
  // ******************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_slave;
    !sync_master_mode_i [*2];
  endsequence
  sequence s_master;
    sync_master_mode_i [*3];
  endsequence
  chk_ack_after_take: assert property (s_take |=> wb_ack_o)
    else $error("request not acknowledged");
  chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  chk_no_idle_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_oe_slave_low: assert property (s_slave |-> !serial_clock_oe_o && !serial_clock_o)
    else $error("serial clock driven outside master mode");
  chk_oe_master_high: assert property (s_master |-> serial_clock_oe_o)
    else $error("serial clock not driven in master mode");
  chk_sclk_follows: assert property (s_master |-> serial_clock_o == internal_divided_clock_o
    || serial_clock_o == $past(internal_divided_clock_o))
    else $error("serial clock differs from internal clock");
  chk_strobe_single: assert property (sample_strobe_o |=> !sample_strobe_o)
    else $error("sample strobe wider than one cycle");
  // a modulator half period spans at least one internal half period
  chk_mod_hold: assert property ($changed(modulator_clock_o) |=> $stable(modulator_clock_o) [*3])
    else $error("modulator clock toggles too fast");
endmodule

bind acd_clock_config acd_clock_config_properties acd_clock_config_properties_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sync_master_mode_i(sync_master_mode_i),
  .serial_clock_o(serial_clock_o), .serial_clock_oe_o(serial_clock_oe_o),
  .internal_divided_clock_o(internal_divided_clock_o),
  .modulator_clock_o(modulator_clock_o), .sample_strobe_o(sample_strobe_o)
);

/* dv/acd_clock_config_tb.sv */
`timescale 1ns/1ps
module acd_clock_config_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        ext_clk = 1'b0;
  logic        ser_clk = 1'b0;
  logic        master = 1'b0;
  logic [3:0]  mon;
  logic        sclk_oe;
  logic [31:0] rd;
  int          err_total = 0;
  int          n_compared = 0;
  int          tick = 0;
  int          p;
  int          osr_len[3] = '{32, 200, 400};
  logic [7:0]  osr_code[3] = '{8'h0f, 8'h09, 8'h06};

  acd_clock_config acd_clock_config_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .external_clock_input_i(ext_clk), .serial_clock_i(ser_clk), .sync_master_mode_i(master),
    .serial_clock_o(mon[3]), .serial_clock_oe_o(sclk_oe), .internal_divided_clock_o(mon[0]),
    .modulator_clock_o(mon[1]), .sample_strobe_o(mon[2])
  );

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // ******************************
  // sources: external 6 cycles, serial 10 cycles, well below half rate
  // ******************************
  always @(posedge clk_i) begin
    tick <= tick + 1;
    if (tick % 3 == 2) ext_clk <= ~ext_clk;
    if (tick % 5 == 4) ser_clk <= ~ser_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wb_io(input logic w, input logic [7:0] a, input logic [7:0] d);
    {cyc, stb, we, sel} <= {2'b11, w, 4'h1};
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    {cyc, stb} <= 2'b00;
    @(posedge clk_i);
  endtask

  // first interval partial, second lets a new setting settle
  task automatic period(input int which, output int cnt);
    logic prev;
    logic cur;
    cur = 1'b1;
    cnt = 0;
    for (int e = 0; e < 3; e++) begin
      cnt = 0;
      do begin
        @(posedge clk_i);
        prev = cur;
        cur = mon[which];
        cnt++;
      end while (!(cur === 1'b1 && prev === 1'b0));
    end
  endtask

  task automatic summarize();
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(90000 * 40);
    err_total++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb_io(1'b0, 8'h34, 8'h00);
    check(rd, 32'h08);
    wb_io(1'b0, 8'h38, 8'h00);
    check(rd, 32'h86);
    wb_io(1'b1, 8'h3c, 8'h5a);
    wb_io(1'b0, 8'h3c, 8'h00);
    check(rd, 32'h0);
    for (int c = 1; c < 8; c++) begin
      wb_io(1'b1, 8'h34, 8'(c << 1));
      period(0, p);
      check(p, 12 * c);
    end
    wb_io(1'b1, 8'h34, 8'h82);
    wb_io(1'b0, 8'h34, 8'h00);
    check(rd, 32'h82);
    period(0, p);
    check(p, 20);
    master <= 1'b1;
    period(3, p);
    check(p, 20);
    check(sclk_oe, 1'b1);
    master <= 1'b0;
    wb_io(1'b1, 8'h34, 8'h02);
    for (int m = 1; m < 8; m++) begin
      wb_io(1'b1, 8'h38, 8'(m << 5) | 8'h0f);
      period(1, p);
      check(p, 24 * m);
    end
    // ascending ratios so the running count never passes a new limit
    for (int i = 0; i < 3; i++) begin
      wb_io(1'b1, 8'h38, 8'h20 | osr_code[i]);
      period(2, p);
      check(p, 24 * osr_len[i]);
    end
    wb_io(1'b0, 8'h80, 8'h00);
    check(rd & 32'h9, 32'h8);
    wb_io(1'b0, 8'h80, 8'h00);
    check(rd & 32'h9, 32'h0);
    summarize();
  end
endmodule

/* inc/acd_pkg.sv */
package acd_pkg;
  // ************************************************************
  // register map (word index, byte address is four times it)
  // ************************************************************
  localparam logic [5:0] IDX_CLOCK_SOURCE_DIVIDER        = 6'h0d;
  localparam logic [5:0] IDX_MODULATOR_CLOCK_OVERSAMPLING = 6'h0e;
  localparam logic [5:0] IDX_CLOCK_STATUS                = 6'h20;

  localparam logic [7:0] RST_CLOCK_SOURCE_DIVIDER        = 8'h08;
  localparam logic [7:0] RST_MODULATOR_CLOCK_OVERSAMPLING = 8'h86;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int SRC_SEL_BIT   = 7;
  localparam int CLK_DIV_MSB   = 3;
  localparam int CLK_DIV_LSB   = 1;
  localparam int MOD_DIV_MSB   = 7;
  localparam int MOD_DIV_LSB   = 5;
  localparam int OSR_MSB       = 3;
  localparam int OSR_LSB       = 0;

  localparam logic [2:0] DIV_CODE_RESERVED = 3'h0;
  localparam int         OSR_CNT_W         = 13;

  // ************************************************************
  // status word carried out to the register file
  // ************************************************************
  typedef struct packed {
    logic       sample_strobe_seen;
    logic       modulator_clock;
    logic       internal_divided_clock;
    logic       source_is_serial;
  } acd_status_t;

  localparam logic [3:0] RST_STATUS = 4'h0;
endpackage

/* logic/acd_clock_config.sv */
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Overview of operation
// [RL1] bit 7 of the first clock register picks the external clock input when 0, serial clock pin when 1.
// [RL2] the chosen clock is divided by 2, 4 .. 14 from code 1..7 in bits 3:1, code 0 is reserved.
// [RL3] in synchronous master mode the divided internal clock is driven out as the serial clock.
// [RL4] the modulator clock is the internal clock divided by 2 .. 14 from bits 7:5 of the second register.
// [RL5] a sample strobe fires once every oversampling-ratio modulator clocks, ratio from bits 3:0.
// [RL6] the first clock register sits at index 0Dh and resets to 08h.
// [RL7] the second clock register sits at index 0Eh and resets to 86h.
// [RL8] software writes zero to the reserved bits of both clock registers.
module acd_clock_config #(
  parameter int ADR_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             external_clock_input_i,
  input  wire logic             serial_clock_i,
  input  wire logic             sync_master_mode_i,
  output logic                  serial_clock_o,
  output logic                  serial_clock_oe_o,
  output logic                  internal_divided_clock_o,
  output logic                  modulator_clock_o,
  output logic                  sample_strobe_o
);

  localparam int OSR_CNT_W_L = acd_pkg::OSR_CNT_W;

  typedef acd_pkg::acd_status_t acd_status_t_local;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [OSR_CNT_W_L-1:0] osr_ratio(input logic [3:0] code);
    case (code)
      4'h0:    osr_ratio = 13'd4096;
      4'h1:    osr_ratio = 13'd2048;
      4'h2:    osr_ratio = 13'd1024;
      4'h3:    osr_ratio = 13'd800;
      4'h4:    osr_ratio = 13'd768;
      4'h5:    osr_ratio = 13'd512;
      4'h6:    osr_ratio = 13'd400;
      4'h7:    osr_ratio = 13'd384;
      4'h8:    osr_ratio = 13'd256;
      4'h9:    osr_ratio = 13'd200;
      4'ha:    osr_ratio = 13'd192;
      4'hb:    osr_ratio = 13'd128;
      4'hc:    osr_ratio = 13'd96;
      4'hd:    osr_ratio = 13'd64;
      4'he:    osr_ratio = 13'd48;
      default: osr_ratio = 13'd32;
    endcase
  endfunction

  // ************************************************************
  // registers and bus slave
  // ************************************************************
  logic [7:0]          clock_source_divider_reg;
  logic [7:0]          modulator_clock_oversampling_reg;
  logic                status_sample_seen_reg;
  logic                bus_hit;
  logic [5:0]          word_idx;
  acd_status_t_local   status;

  assign bus_hit  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign word_idx = wb_adr_i[7:2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_hit;
    end
  end

  // reserved bits are stored as written; software keeps them zero [RL8]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_source_divider_reg         <= acd_pkg::RST_CLOCK_SOURCE_DIVIDER;         // [RL6]
      modulator_clock_oversampling_reg <= acd_pkg::RST_MODULATOR_CLOCK_OVERSAMPLING; // [RL7]
    end else if (bus_hit && wb_we_i && wb_sel_i[0]) begin
      if (word_idx == acd_pkg::IDX_CLOCK_SOURCE_DIVIDER) begin
        clock_source_divider_reg <= wb_dat_i[7:0]; // [RL6]
      end
      if (word_idx == acd_pkg::IDX_MODULATOR_CLOCK_OVERSAMPLING) begin
        modulator_clock_oversampling_reg <= wb_dat_i[7:0]; // [RL7]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_hit && !wb_we_i) begin
      unique case (word_idx)
        acd_pkg::IDX_CLOCK_SOURCE_DIVIDER:
          wb_dat_o <= {24'h00_0000, clock_source_divider_reg};
        acd_pkg::IDX_MODULATOR_CLOCK_OVERSAMPLING:
          wb_dat_o <= {24'h00_0000, modulator_clock_oversampling_reg};
        acd_pkg::IDX_CLOCK_STATUS:
          wb_dat_o <= {28'h000_0000, status};
        default:
          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] ext_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic       src_prev_reg;
  logic       src_level;
  logic       src_rise;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_sync_reg  <= 2'h0;
      sclk_sync_reg <= 2'h0;
    end else begin
      ext_sync_reg  <= {ext_sync_reg[0], external_clock_input_i};
      sclk_sync_reg <= {sclk_sync_reg[0], serial_clock_i};
    end
  end

  // source switch is glitch-free only in the sense of edge counting; a swap
  // mid-period can stretch one internal half period
  assign src_level = clock_source_divider_reg[acd_pkg::SRC_SEL_BIT] ?
                     sclk_sync_reg[1] : ext_sync_reg[1]; // [RL1]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  assign src_rise = src_level && !src_prev_reg;

  // ************************************************************
  // internal clock divider
  // ************************************************************
  logic [2:0] clk_div_code;
  logic [2:0] internal_divided_clock_cnt_reg;
  logic       internal_divided_clock_reg;
  logic       internal_divided_clock_rise;

  assign clk_div_code = clock_source_divider_reg[acd_pkg::CLK_DIV_MSB:acd_pkg::CLK_DIV_LSB];
  // half period = code source edges, so ratio = 2 * code; code 0 holds the clock
  assign internal_divided_clock_rise = src_rise && (clk_div_code != acd_pkg::DIV_CODE_RESERVED)
                     && (internal_divided_clock_cnt_reg >= clk_div_code - 3'h1) && !internal_divided_clock_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      internal_divided_clock_cnt_reg <= 3'h0;
      internal_divided_clock_reg     <= 1'b0;
    end else if (src_rise && clk_div_code != acd_pkg::DIV_CODE_RESERVED) begin // [RL2]
      if (internal_divided_clock_cnt_reg >= clk_div_code - 3'h1) begin
        internal_divided_clock_cnt_reg <= 3'h0;
        internal_divided_clock_reg     <= !internal_divided_clock_reg;
      end else begin
        internal_divided_clock_cnt_reg <= internal_divided_clock_cnt_reg + 3'h1;
      end
    end
  end

  // ************************************************************
  // modulator clock divider
  // ************************************************************
  logic [2:0] mod_div_code;
  logic [2:0] mod_cnt_reg;
  logic       mod_reg;
  logic       mod_rise;

  assign mod_div_code = modulator_clock_oversampling_reg[acd_pkg::MOD_DIV_MSB:acd_pkg::MOD_DIV_LSB];
  assign mod_rise = internal_divided_clock_rise && (mod_div_code != acd_pkg::DIV_CODE_RESERVED)
                    && (mod_cnt_reg >= mod_div_code - 3'h1) && !mod_reg;

  // only internal rising edges count, so ratio = 2 * code
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod_cnt_reg <= 3'h0;
      mod_reg     <= 1'b0;
    end else if (internal_divided_clock_rise && mod_div_code != acd_pkg::DIV_CODE_RESERVED) begin // [RL4]
      if (mod_cnt_reg >= mod_div_code - 3'h1) begin
        mod_cnt_reg <= 3'h0;
        mod_reg     <= !mod_reg;
      end else begin
        mod_cnt_reg <= mod_cnt_reg + 3'h1;
      end
    end
  end

  // ************************************************************
  // oversampling counter and sample strobe
  // ************************************************************
  logic [OSR_CNT_W_L-1:0] osr_cnt_reg;
  logic [OSR_CNT_W_L-1:0] osr_target;
  logic                   sample_reg;

  assign osr_target = osr_ratio(modulator_clock_oversampling_reg[acd_pkg::OSR_MSB:acd_pkg::OSR_LSB]);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osr_cnt_reg <= '0;
      sample_reg  <= 1'b0;
    end else begin
      sample_reg <= 1'b0;
      if (mod_rise) begin // [RL5]
        if (osr_cnt_reg >= osr_target - 13'd1) begin
          osr_cnt_reg <= '0;
          sample_reg  <= 1'b1;
        end else begin
          osr_cnt_reg <= osr_cnt_reg + 13'd1;
        end
      end
    end
  end

  // sticky until the status word is read; a new strobe wins over the read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_sample_seen_reg <= 1'b0;
    end else if (sample_reg) begin
      status_sample_seen_reg <= 1'b1;
    end else if (bus_hit && !wb_we_i && word_idx == acd_pkg::IDX_CLOCK_STATUS) begin
      status_sample_seen_reg <= 1'b0;
    end
  end

  assign status = '{sample_strobe_seen:     status_sample_seen_reg,
                    modulator_clock:        mod_reg,
                    internal_divided_clock: internal_divided_clock_reg,
                    source_is_serial:       clock_source_divider_reg[acd_pkg::SRC_SEL_BIT]};

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_clock_o           <= 1'b0;
      serial_clock_oe_o        <= 1'b0;
      internal_divided_clock_o <= 1'b0;
      modulator_clock_o        <= 1'b0;
      sample_strobe_o          <= 1'b0;
    end else begin
      serial_clock_o           <= sync_master_mode_i && internal_divided_clock_reg; // [RL3]
      serial_clock_oe_o        <= sync_master_mode_i;             // [RL3]
      internal_divided_clock_o <= internal_divided_clock_reg;
      modulator_clock_o        <= mod_reg;
      sample_strobe_o          <= sample_reg;
    end
  end

endmodule
